//--- hw/acs_pkg.sv
// package for the conversion sequencer: offsets, field layout, types
`default_nettype none
package acs_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ACS_OFF_INS_OFS0 = 8'h14;
  localparam logic [7:0] ACS_OFF_INS_OFS1 = 8'h18;
  localparam logic [7:0] ACS_OFF_INS_OFS2 = 8'h1c;
  localparam logic [7:0] ACS_OFF_INS_OFS3 = 8'h20;
  localparam logic [7:0] ACS_OFF_RSQ_UP   = 8'h2c;
  localparam logic [7:0] ACS_OFF_RSQ_MID  = 8'h30;
  localparam logic [7:0] ACS_OFF_RSQ_LOW  = 8'h34;
  localparam logic [7:0] ACS_OFF_ISQ      = 8'h38;
  localparam logic [7:0] ACS_OFF_STATUS   = 8'h50;
  // ==========================================================
  // field layout
  localparam int ACS_SLOT_W      = 5;
  localparam int ACS_RLEN_LSB    = 20;
  localparam int ACS_RLEN_W      = 4;
  localparam int ACS_ILEN_LSB    = 20;
  localparam int ACS_ILEN_W      = 2;
  localparam int ACS_UP_W        = 24;  // length plus slots 12..15
  localparam int ACS_MID_W       = 30;  // six slots
  localparam int ACS_ISQ_W       = 22;  // length plus four slots
  localparam int ACS_OFS_W       = 12;
  localparam int ACS_DATA_W      = 16;
  localparam int ACS_REG_SLOTS   = 16;
  localparam int ACS_INS_SLOTS   = 4;
  localparam logic [3:0] ACS_INS_LAST = 4'h3;
  // ==========================================================
  // reset values
  localparam logic [31:0] ACS_RST_VAL = 32'h0000_0000;
  // ==========================================================
  // types
  typedef enum logic [1:0] {ACS_IDLE, ACS_REGULAR, ACS_INSERTED} acs_state_t;
  typedef struct packed {
    logic [3:0]            slot;     // position within its group
    logic [ACS_SLOT_W-1:0] channel;  // converted channel
    logic [ACS_DATA_W-1:0] data;     // result word
  } acs_result_t;
endpackage : acs_pkg
`default_nettype wire

//--- hw/acs_sequencer.sv
// conversion sequencer: sequence registers, slot ordering, inserted offset
//
// Added by the designer: the plain strobed port.
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  regular_trigger,
  input  wire logic                  inserted_trigger,
  output logic                       conv_start,
  output logic      [ACS_SLOT_W-1:0] conv_channel,
  input  wire logic                  conv_done,
  input  wire logic [ACS_OFS_W-1:0]  conv_raw,
  output logic                       regular_valid,
  output logic                       inserted_valid,
  output acs_result_t                result,
  output logic                       busy
);

  // ==========================================================
  // registers
  logic [ACS_UP_W-1:0]   rsq_up_q;
  logic [ACS_MID_W-1:0]  rsq_mid_q;
  logic [ACS_MID_W-1:0]  rsq_low_q;
  logic [ACS_ISQ_W-1:0]  isq_q;
  logic [ACS_OFS_W-1:0]  offset_q [ACS_INS_SLOTS];
  logic [31:0]           rdata_q;
  acs_state_t            state_q;
  logic [3:0]            slot_q;
  logic                  start_q;
  logic [ACS_SLOT_W-1:0] chan_q;
  logic                  reg_valid_q;
  logic                  ins_valid_q;
  acs_result_t           result_q;

  // ==========================================================
  // address decode
  wire sel_up  = (reg_addr == ACS_OFF_RSQ_UP);
  wire sel_mid = (reg_addr == ACS_OFF_RSQ_MID);
  wire sel_low = (reg_addr == ACS_OFF_RSQ_LOW);
  wire sel_isq = (reg_addr == ACS_OFF_ISQ);
  wire sel_st  = (reg_addr == ACS_OFF_STATUS);
  wire wr_up   = reg_wr && sel_up;
  wire wr_mid  = reg_wr && sel_mid;
  wire wr_low  = reg_wr && sel_low;
  wire wr_isq  = reg_wr && sel_isq;

  // ==========================================================
  // field views; slots packed five bits apart, lowest slot at bit 0
  wire [ACS_RLEN_W-1:0] reg_len = rsq_up_q[ACS_RLEN_LSB +: ACS_RLEN_W];
  wire [ACS_ILEN_W-1:0] ins_len = isq_q[ACS_ILEN_LSB +: ACS_ILEN_W];
  wire [ACS_SLOT_W*ACS_REG_SLOTS-1:0] reg_slots =
    {rsq_up_q[ACS_SLOT_W*4-1:0], rsq_mid_q, rsq_low_q};
  wire [ACS_SLOT_W*ACS_INS_SLOTS-1:0] ins_slots =
    isq_q[ACS_SLOT_W*ACS_INS_SLOTS-1:0];
  // first inserted slot: right-justified toward slot 3
  wire [3:0] ins_first = ACS_INS_LAST - {2'b00, ins_len};

  // ==========================================================
  // per-slot channel selection
  wire [3:0] slot_next   = slot_q + 4'h1;
  wire [ACS_SLOT_W-1:0] reg_ch_first = reg_slots[0 +: ACS_SLOT_W];
  wire [ACS_SLOT_W-1:0] reg_ch_next  = reg_slots[ACS_SLOT_W*slot_next +: ACS_SLOT_W];
  wire [ACS_SLOT_W-1:0] ins_ch_first = ins_slots[ACS_SLOT_W*ins_first[1:0] +: ACS_SLOT_W];
  wire [ACS_SLOT_W-1:0] ins_ch_next  = ins_slots[ACS_SLOT_W*slot_next[1:0] +: ACS_SLOT_W];

  // ==========================================================
  // end-of-group detection
  wire reg_last = (slot_q == reg_len);
  wire ins_last = (slot_q == ACS_INS_LAST);
  wire in_reg   = (state_q == ACS_REGULAR);
  wire in_ins   = (state_q == ACS_INSERTED);
  wire go_ins   = (state_q == ACS_IDLE) && inserted_trigger;
  wire go_reg   = (state_q == ACS_IDLE) && regular_trigger && !inserted_trigger;

  // ==========================================================
  // inserted offset subtraction; negative results wrap two's complement
  wire [ACS_OFS_W-1:0] ins_off = offset_q[slot_q[1:0]];
  wire [ACS_DATA_W-1:0] ins_data =
    {4'h0, conv_raw} - {4'h0, ins_off};

  // ==========================================================
  // read mux; unmapped offsets read zero
  wire [31:0] status_word = {24'h0, 2'b00, state_q, slot_q};
  wire [31:0] rd_mux =
    sel_up  ? {8'h00, rsq_up_q} :
    sel_mid ? {2'b00, rsq_mid_q} :
    sel_low ? {2'b00, rsq_low_q} :
    sel_isq ? {10'h000, isq_q} :
    sel_st  ? status_word :
    (reg_addr == ACS_OFF_INS_OFS0) ? {20'h00000, offset_q[0]} :
    (reg_addr == ACS_OFF_INS_OFS1) ? {20'h00000, offset_q[1]} :
    (reg_addr == ACS_OFF_INS_OFS2) ? {20'h00000, offset_q[2]} :
    (reg_addr == ACS_OFF_INS_OFS3) ? {20'h00000, offset_q[3]} : 32'h0000_0000;

  // ==========================================================
  // sequence registers; reserved bits are not stored and read zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rsq_up_q  <= ACS_RST_VAL[ACS_UP_W-1:0];
      rsq_mid_q <= ACS_RST_VAL[ACS_MID_W-1:0];
      rsq_low_q <= ACS_RST_VAL[ACS_MID_W-1:0];
      isq_q     <= ACS_RST_VAL[ACS_ISQ_W-1:0];
    end else begin
      if (wr_up)  rsq_up_q  <= reg_wdata[ACS_UP_W-1:0];
      if (wr_mid) rsq_mid_q <= reg_wdata[ACS_MID_W-1:0];
      if (wr_low) rsq_low_q <= reg_wdata[ACS_MID_W-1:0];
      if (wr_isq) isq_q     <= reg_wdata[ACS_ISQ_W-1:0];
    end
  end

  // offset registers, one per inserted slot
  for (genvar i = 0; i < ACS_INS_SLOTS; i++) begin : g_offset
    localparam logic [7:0] OFF = ACS_OFF_INS_OFS0 + 8'(4 * i);
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        offset_q[i] <= ACS_RST_VAL[ACS_OFS_W-1:0];
      end else if (reg_wr && reg_addr == OFF) begin
        offset_q[i] <= reg_wdata[ACS_OFS_W-1:0];
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_q <= ACS_RST_VAL;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================================
  // slot walker; triggers while busy are ignored, inserted wins at idle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= ACS_IDLE;
      slot_q  <= 4'h0;
      start_q <= 1'b0;
      chan_q  <= 5'h00;
    end else begin
      start_q <= 1'b0;
      unique case (state_q)
        ACS_IDLE: begin
          if (go_ins) begin
            state_q <= ACS_INSERTED;
            slot_q  <= ins_first;
            chan_q  <= ins_ch_first;
            start_q <= 1'b1;
          end else if (go_reg) begin
            state_q <= ACS_REGULAR;
            slot_q  <= 4'h0;
            chan_q  <= reg_ch_first;
            start_q <= 1'b1;
          end
        end
        ACS_REGULAR: begin
          if (conv_done) begin
            if (reg_last) begin
              state_q <= ACS_IDLE;
            end else begin
              slot_q  <= slot_next;
              chan_q  <= reg_ch_next;
              start_q <= 1'b1;
            end
          end
        end
        ACS_INSERTED: begin
          if (conv_done) begin
            if (ins_last) begin
              state_q <= ACS_IDLE;
            end else begin
              slot_q  <= slot_next;
              chan_q  <= ins_ch_next;
              start_q <= 1'b1;
            end
          end
        end
        default: state_q <= ACS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // result capture; done outside a run is dropped
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_valid_q <= 1'b0;
      ins_valid_q <= 1'b0;
      result_q    <= '0;
    end else begin
      reg_valid_q <= conv_done && in_reg;
      ins_valid_q <= conv_done && in_ins;
      if (conv_done && (in_reg || in_ins)) begin
        result_q.slot    <= slot_q;
        result_q.channel <= chan_q;
        result_q.data    <= in_ins ? ins_data : {4'h0, conv_raw};
      end
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata      = rdata_q;
  assign conv_start     = start_q;
  assign conv_channel   = chan_q;
  assign regular_valid  = reg_valid_q;
  assign inserted_valid = ins_valid_q;
  assign result         = result_q;
  assign busy           = (state_q != ACS_IDLE);

  // ==========================================================
  // checks
  chk_regular_run_end: assert property (@(posedge sys_clk) disable iff (!resetn)
    in_reg && conv_done && slot_q == reg_len |=> state_q == ACS_IDLE)
    else $error("regular run did not stop at programmed length");

  chk_regular_step_up: assert property (@(posedge sys_clk) disable iff (!resetn)
    in_reg && conv_done && slot_q != reg_len
      |=> in_reg && slot_q == $past(slot_q) + 4'h1 && conv_start)
    else $error("regular slot did not advance by one");

  chk_regular_first: assert property (@(posedge sys_clk) disable iff (!resetn)
    go_reg |=> slot_q == 4'h0 && conv_channel == $past(rsq_low_q[4:0]) && conv_start)
    else $error("regular run did not begin at slot zero");

  chk_regular_channel: assert property (@(posedge sys_clk) disable iff (!resetn)
    in_reg && conv_start |-> conv_channel == reg_slots[ACS_SLOT_W*slot_q +: ACS_SLOT_W])
    else $error("regular channel does not match its slot");

  chk_inserted_first: assert property (@(posedge sys_clk) disable iff (!resetn)
    go_ins |=> in_ins && slot_q == 4'h3 - {2'b00, $past(ins_len)})
    else $error("inserted run started at wrong slot");

  chk_inserted_end: assert property (@(posedge sys_clk) disable iff (!resetn)
    in_ins && conv_done && slot_q == 4'h3 |=> !busy ##0 inserted_valid)
    else $error("inserted run did not end after slot three");

  chk_inserted_offset: assert property (@(posedge sys_clk) disable iff (!resetn)
    in_ins && conv_done
      |=> result.data == 16'($past({4'h0, conv_raw}) - $past({4'h0, ins_off})))
    else $error("inserted result lacks offset subtraction");

  chk_start_single: assert property (@(posedge sys_clk) disable iff (!resetn)
    conv_start |=> !conv_start)
    else $error("conversion start held longer than one cycle");

  chk_length_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_up |=> reg_len == $past(reg_wdata[23:20]))
    else $error("regular length field not stored from bits 23:20");

  chk_inserted_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_isq |=> ins_slots[19:15] == $past(reg_wdata[19:15]) && ins_len == $past(reg_wdata[21:20]))
    else $error("inserted sequence fields not stored");

  // register bus, channel selection and result valid; read data must not linger past its cycle
  chk_read_idle_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data present without a read strobe");

  chk_upper_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && sel_up |=> reg_rdata[31:24] == 8'h00 && reg_rdata[23:20] == $past(reg_len))
    else $error("upper register read shows wrong length or reserved bits");

  chk_lower_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_low |=> reg_slots[29:0] == $past(reg_wdata[29:0]))
    else $error("lower register not stored as slots zero to five");

  chk_middle_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_mid |=> reg_slots[59:30] == $past(reg_wdata[29:0]))
    else $error("middle register not stored as slots six to eleven");

  chk_upper_slots: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_up |=> reg_slots[79:60] == $past(reg_wdata[19:0]))
    else $error("upper register not stored as slots twelve to fifteen");

  chk_inserted_channel: assert property (@(posedge sys_clk) disable iff (!resetn)
    in_ins && conv_start |-> conv_channel == ins_slots[ACS_SLOT_W*slot_q[1:0] +: ACS_SLOT_W])
    else $error("inserted channel does not match its slot");

  chk_valid_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    regular_valid || inserted_valid |=> !regular_valid && !inserted_valid)
    else $error("result valid held longer than one cycle");

  chk_status_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && sel_st |=> reg_rdata[5:4] == $past(state_q) && reg_rdata[3:0] == $past(slot_q))
    else $error("status read does not show state and slot");

endmodule : acs_sequencer
`default_nettype wire

//--- verification/acs_core_model.sv
// converter core stand-in: answers each start with one done, prompt or slow
`default_nettype none
module acs_core_model
  import acs_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  slow,
  input  wire logic                  conv_start,
  input  wire logic [ACS_SLOT_W-1:0] conv_channel,
  output logic                       conv_done,
  output logic      [ACS_OFS_W-1:0]  conv_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_q;
  // ==========================================================
  // one done per start, never in the start cycle; raw follows channel
  always_ff @(posedge sys_clk) begin
    conv_done <= 1'b0;
    conv_raw  <= ~conv_raw;  // raw toggles so a stale sample never matches
    if (!resetn) begin
      wait_q   <= 3'h0;
      conv_raw <= 12'h000;
    end else if (conv_start && slow) begin
      wait_q <= 3'h4;
    end else if (conv_start || wait_q == 3'h1) begin
      wait_q    <= 3'h0;
      conv_done <= 1'b1;
      conv_raw  <= {conv_channel, 7'h2b};
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end
  end
endmodule : acs_core_model
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the conversion sequencer
`default_nettype none
module tb
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0, resetn = 1'b0, slow = 1'b0, rd_d = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, regular_trigger = 1'b0, inserted_trigger = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        conv_start, conv_done, regular_valid, inserted_valid, busy;
  logic [4:0]  conv_channel, rs [16], is [4];
  logic [11:0] conv_raw, off [4];
  logic [3:0]  rlen;
  logic [1:0]  ilen;
  acs_result_t result;
  logic [31:0] rq [$], vq [$];
  int          error_cnt = 0, compares = 0, cyc = 0;
  localparam logic [7:0] ADDRS [8] = '{ACS_OFF_RSQ_UP, ACS_OFF_RSQ_MID, ACS_OFF_RSQ_LOW,
    ACS_OFF_ISQ, ACS_OFF_INS_OFS0, ACS_OFF_INS_OFS1, ACS_OFF_INS_OFS2, ACS_OFF_INS_OFS3};
  always #2.5 sys_clk = ~sys_clk;
  acs_sequencer acs_sequencer_i (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .regular_trigger(regular_trigger), .inserted_trigger(inserted_trigger),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_raw(conv_raw), .regular_valid(regular_valid), .inserted_valid(inserted_valid),
    .result(result), .busy(busy));
  acs_core_model acs_core_model_i (.sys_clk(sys_clk), .resetn(resetn), .slow(slow),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_raw(conv_raw));
  // ==========================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // ==========================================================
  // register bus: one strobe per edge, lowered only by idle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    if (!w) rq.push_back(d);  // for reads d is the expected data
  endtask : bus
  task automatic idle();
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : idle
  // pack the tb's slot tables into words, write all, read all back
  task automatic cfg();
    logic [31:0] v [8];
    foreach (v[r]) v[r] = 32'h0;  // reserved bits stay zero
    foreach (rs[i]) v[i < 6 ? 2 : i < 12 ? 1 : 0][5 * (i % 6) +: 5] = rs[i];
    v[0][23:20] = rlen;
    v[3][21:20] = ilen;
    foreach (is[k]) begin
      v[3][5 * k +: 5] = is[k];
      v[4 + k][11:0]   = off[k];
    end
    foreach (v[r]) bus(1'b1, ADDRS[r], v[r]);
    foreach (v[r]) bus(1'b0, ADDRS[r], v[r]);
    idle();
  endtask : cfg
  // note expected results, trigger, retrigger while busy, wait for idle
  task automatic run(input logic ins);
    int n;
    if (ins) begin
      for (int k = 3 - ilen; k < 4; k++)
        vq.push_back({6'h0, 1'b1, 4'(k), is[k], 16'({is[k], 7'h2b}) - 16'(off[k])});
    end else begin
      for (int i = 0; i <= rlen; i++)
        vq.push_back({6'h0, 1'b0, 4'(i), rs[i], 16'({rs[i], 7'h2b})});
    end
    @(posedge sys_clk);
    regular_trigger  <= 1'b1;  // both high for inserted: inserted must win at idle
    inserted_trigger <= ins;
    @(posedge sys_clk);
    regular_trigger  <= 1'b0;
    inserted_trigger <= 1'b0;
    @(posedge sys_clk);
    regular_trigger  <= 1'b1;  // mid-run request must be ignored
    inserted_trigger <= 1'b1;
    @(posedge sys_clk);
    regular_trigger  <= 1'b0;
    inserted_trigger <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (busy !== 1'b0 && n < 200);
    chk(32'(n < 200), 32'h1);
  endtask : run
  // ==========================================================
  // monitor: oldest note against each read answer and each result
  always @(posedge sys_clk) begin
    cyc  <= cyc + 1;
    rd_d <= reg_rd;
    if (rd_d) chk(reg_rdata, rq.size() ? rq.pop_front() : 32'hx);
    if (regular_valid === 1'b1 || inserted_valid === 1'b1)
      chk({6'h0, inserted_valid, result}, vq.size() ? vq.pop_front() : 32'hx);
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hc6e00410));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (ADDRS[r]) bus(1'b0, ADDRS[r], ACS_RST_VAL);
    bus(1'b0, ACS_OFF_STATUS, ACS_RST_VAL);
    bus(1'b1, 8'h00, 32'hffff_ffff);
    bus(1'b0, 8'h00, 32'h0);
    idle();
    $display("reset and unmapped test done");
    for (int t = 0; t < 6; t++) begin
      foreach (rs[i]) rs[i] = 5'($urandom_range(18));
      foreach (is[k]) is[k] = 5'($urandom_range(18));
      foreach (off[k]) off[k] = 12'($urandom);
      rlen = (t == 0) ? 4'h0 : (t == 1) ? 4'hf : 4'($urandom);
      ilen = 2'(t);
      slow <= t[0];
      cfg();
      run(1'b0);
      run(1'b1);
      bus(1'b0, ACS_OFF_STATUS, {28'h0, ACS_INS_LAST});
      idle();
      $display("sequence test %0d done", t);
    end
    repeat (4) @(posedge sys_clk);
    chk(32'(vq.size()), 32'h0);
    end_sim();
  end
endmodule : tb
`default_nettype wire
